// ### rcvr_defs.vh
// Register numbers, fields, reset values and timing of the value bank.
`ifndef RCVR_DEFS_VH
`define RCVR_DEFS_VH

`define RCVR_REG_MAN_ADJUST     8'h15
`define RCVR_REG_PRESENCE       8'h16
`define RCVR_REG_BUS_TEMP       8'h1E
`define RCVR_REG_CTRL_REQ       8'h1F
`define RCVR_REG_SP_OFFSET      8'h22
`define RCVR_REG_OPMODE_REQ     8'h24
`define RCVR_REG_CHANGEOVER     8'h26
`define RCVR_REG_DEW_POINT      8'h27
`define RCVR_REG_SETPOINT       8'h29
`define RCVR_REG_ANA_A_DRIVE    8'h2D
`define RCVR_REG_ANA_B_DRIVE    8'h2E
`define RCVR_REG_PULSE_A_DRIVE  8'h2F
`define RCVR_REG_PULSE_B_DRIVE  8'h30
`define RCVR_REG_EFF_ACTUAL     8'h32
`define RCVR_REG_CTRL_CUR       8'h33
`define RCVR_REG_WINDOW         8'h35
`define RCVR_REG_EFF_SETPOINT   8'h36
`define RCVR_REG_MAN_HEAT       8'h38
`define RCVR_REG_MAN_COOL       8'h39
`define RCVR_REG_OPMODE_CUR     8'h3B
`define RCVR_REG_AUX_CONTACT    8'h46
`define RCVR_REG_TEMPERATURE    8'h47
`define RCVR_REG_VOLTAGE        8'h48
`define RCVR_REG_COOL_LIMIT     8'h8E
`define RCVR_REG_HEAT_LIMIT     8'h8F
`define RCVR_REG_INVERSION      8'h90

`define RCVR_CM_AUTO            4'h0
`define RCVR_CM_HEAT            4'h1
`define RCVR_CM_COOL            4'h3
`define RCVR_CM_FROST           4'h5
`define RCVR_CM_OFF             4'h6
`define RCVR_CM_MANUAL          4'hA

`define RCVR_OM_COMFORT         3'h0
`define RCVR_OM_REDUCED         3'h1
`define RCVR_OM_STANDBY         3'h2
`define RCVR_OM_FIXED_REDUCED   3'h5

`define RCVR_PCT_MAX            7'h64
`define RCVR_LIMIT_RESET        7'h64
`define RCVR_OFFSET_MIN         (-8'sd30)
`define RCVR_OFFSET_MAX         (8'sd30)
`define RCVR_INV_PULSE_A        0
`define RCVR_INV_PULSE_B        1
`define RCVR_INV_ANA_A          2
`define RCVR_INV_ANA_B          3

`define RCVR_RUNDOWN_STEP_MIN   10
`define RCVR_CLK_HZ             100000000
`define RCVR_RUNDOWN_STEP_CYC   (40'd60 * `RCVR_RUNDOWN_STEP_MIN * `RCVR_CLK_HZ)
`define RCVR_RUNDOWN_MAX        5'd24

`endif

// ### rcvr_value_regs.v
// Run-time value register bank of the room temperature controller.
`timescale 1ns/1ns
`default_nettype none
`include "rcvr_defs.vh"

module rcvr_value_regs #(
  parameter [39:0] RUNDOWN_STEP_CYCLES = `RCVR_RUNDOWN_STEP_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Register port, addressed by register number
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  // Configuration values held elsewhere
  input  wire [15:0] base_setpoint_cfg,
  input  wire [4:0]  rundown_steps_cfg,
  input  wire        window_polarity_cfg,
  input  wire        bus_temp_select_cfg,
  // Field inputs
  input  wire        window_contact_input,
  input  wire        aux_contact_input,
  input  wire [15:0] temperature_value,
  input  wire [15:0] aux_voltage_input,
  input  wire        presence_detected,
  input  wire [7:0]  manual_adjust_value,
  // Application demands and output ownership
  input  wire        pulse_out_a_free,
  input  wire        pulse_out_b_free,
  input  wire        analog_out_a_free,
  input  wire        analog_out_b_free,
  input  wire [6:0]  app_pulse_a,
  input  wire [6:0]  app_pulse_b,
  input  wire [6:0]  app_analog_a,
  input  wire [6:0]  app_analog_b,
  input  wire [6:0]  app_heat_valve,
  input  wire [6:0]  app_cool_valve,
  // Values handed to the control and output stages
  output reg  [3:0]  control_mode,
  output reg  [2:0]  operating_mode,
  output reg  [15:0] effective_setpoint,
  output reg  [15:0] effective_actual,
  output reg         changeover_cooling,
  output reg         dew_point_wet,
  output reg  [6:0]  heat_valve_pct,
  output reg  [6:0]  cool_valve_pct,
  output reg  [6:0]  pulse_out_a,
  output reg  [6:0]  pulse_out_b,
  output reg  [6:0]  analog_out_a,
  output reg  [6:0]  analog_out_b
);

  // Percentages above full scale are clipped rather than wrapped.
  function [6:0] rcvr_clip;
    input [6:0] v;
    begin
      rcvr_clip = (v > `RCVR_PCT_MAX) ? `RCVR_PCT_MAX : v;
    end
  endfunction

  function [6:0] rcvr_invert;
    input [6:0] v;
    input       inv;
    reg   [6:0] c;
    begin
      c = rcvr_clip(v);
      rcvr_invert = inv ? (`RCVR_PCT_MAX - c) : c;
    end
  endfunction

  function [6:0] rcvr_limit;
    input [6:0] v;
    input [6:0] lim;
    reg   [6:0] c;
    reg   [6:0] l;
    begin
      c = rcvr_clip(v);
      l = rcvr_clip(lim);
      rcvr_limit = (c > l) ? l : c;
    end
  endfunction

  function [31:0] rcvr_pct_word;
    input [6:0] v;
    begin
      rcvr_pct_word = {25'h0000000, v};
    end
  endfunction

  // Writable registers.
  reg [15:0] bus_temp_q;
  reg [3:0]  ctrl_req_q;
  reg [7:0]  sp_offset_q;
  reg [2:0]  opmode_req_q;
  reg        changeover_q;
  reg        dew_point_q;
  reg [15:0] setpoint_q;
  reg [6:0]  ana_a_drive_q;
  reg [6:0]  ana_b_drive_q;
  reg [6:0]  pulse_a_drive_q;
  reg [6:0]  pulse_b_drive_q;
  reg [6:0]  man_heat_q;
  reg [6:0]  man_cool_q;
  reg [6:0]  cool_limit_q;
  reg [6:0]  heat_limit_q;
  reg [3:0]  inversion_q;

  // Run-down timing.
  reg [39:0] step_cnt_q;
  reg [4:0]  rundown_q;
  reg        presence_q;

  wire wr_hit = reg_wr;
  wire window_open = window_contact_input ^ window_polarity_cfg;
  wire rundown_active = (rundown_q != 5'h00);

  always @(posedge clk) begin
    if (reset) begin
      bus_temp_q      <= 16'h0000;
      ctrl_req_q      <= `RCVR_CM_AUTO;
      sp_offset_q     <= 8'h00;
      opmode_req_q    <= `RCVR_OM_COMFORT;
      changeover_q    <= 1'b0;
      dew_point_q     <= 1'b0;
      // A synchronous reset may take the configured value directly.
      setpoint_q      <= base_setpoint_cfg;
      ana_a_drive_q   <= 7'h00;
      ana_b_drive_q   <= 7'h00;
      pulse_a_drive_q <= 7'h00;
      pulse_b_drive_q <= 7'h00;
      man_heat_q      <= 7'h00;
      man_cool_q      <= 7'h00;
      cool_limit_q    <= `RCVR_LIMIT_RESET;
      heat_limit_q    <= `RCVR_LIMIT_RESET;
      inversion_q     <= 4'h0;
    end else if (wr_hit) begin
      // Writes to read-only numbers fall through untouched.
      case (reg_addr)
        `RCVR_REG_BUS_TEMP:     bus_temp_q      <= reg_wdata[15:0];
        `RCVR_REG_CTRL_REQ:     ctrl_req_q      <= reg_wdata[3:0];
        `RCVR_REG_SP_OFFSET:    sp_offset_q     <= reg_wdata[7:0];
        `RCVR_REG_OPMODE_REQ:   opmode_req_q    <= reg_wdata[2:0];
        `RCVR_REG_CHANGEOVER:   changeover_q    <= reg_wdata[0];
        `RCVR_REG_DEW_POINT:    dew_point_q     <= reg_wdata[0];
        `RCVR_REG_SETPOINT:     setpoint_q      <= reg_wdata[15:0];
        `RCVR_REG_ANA_A_DRIVE:  ana_a_drive_q   <= reg_wdata[6:0];
        `RCVR_REG_ANA_B_DRIVE:  ana_b_drive_q   <= reg_wdata[6:0];
        `RCVR_REG_PULSE_A_DRIVE: pulse_a_drive_q <= reg_wdata[6:0];
        `RCVR_REG_PULSE_B_DRIVE: pulse_b_drive_q <= reg_wdata[6:0];
        `RCVR_REG_MAN_HEAT:     man_heat_q      <= reg_wdata[6:0];
        `RCVR_REG_MAN_COOL:     man_cool_q      <= reg_wdata[6:0];
        `RCVR_REG_COOL_LIMIT:   cool_limit_q    <= reg_wdata[6:0];
        `RCVR_REG_HEAT_LIMIT:   heat_limit_q    <= reg_wdata[6:0];
        `RCVR_REG_INVERSION:    inversion_q     <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Presence restarts the run-down count; each step lasts ten minutes.
  always @(posedge clk) begin
    if (reset) begin
      step_cnt_q <= 40'h0000000000;
      rundown_q  <= 5'h00;
      presence_q <= 1'b0;
    end else begin
      presence_q <= presence_detected;
      if (presence_detected) begin
        step_cnt_q <= 40'h0000000000;
        rundown_q  <= (rundown_steps_cfg > `RCVR_RUNDOWN_MAX) ?
                      `RCVR_RUNDOWN_MAX : rundown_steps_cfg;
      end else if (rundown_active) begin
        if (step_cnt_q >= RUNDOWN_STEP_CYCLES - 40'h0000000001) begin
          step_cnt_q <= 40'h0000000000;
          rundown_q  <= rundown_q - 5'h01;
        end else begin
          step_cnt_q <= step_cnt_q + 40'h0000000001;
        end
      end else begin
        step_cnt_q <= 40'h0000000000;
      end
    end
  end

  // Effective modes and values, registered so every output comes from a flop.
  reg [2:0]  opmode_d;
  reg [3:0]  ctrl_d;
  reg [15:0] eff_sp_d;
  reg [7:0]  off_clip;
  reg        manual;

  always @* begin
    case (opmode_req_q)
      `RCVR_OM_COMFORT: opmode_d = `RCVR_OM_COMFORT;
      `RCVR_OM_REDUCED: opmode_d = (presence_q || rundown_active) ?
                                   `RCVR_OM_COMFORT :
                                   `RCVR_OM_REDUCED;
      `RCVR_OM_STANDBY: opmode_d = presence_q ? `RCVR_OM_COMFORT :
                                   `RCVR_OM_STANDBY;
      `RCVR_OM_FIXED_REDUCED: opmode_d = `RCVR_OM_REDUCED;
      default: opmode_d = `RCVR_OM_COMFORT;
    endcase
    // An open window overrides any request with frost protection.
    ctrl_d = window_open ? `RCVR_CM_FROST : ctrl_req_q;
    // The offset is clipped here because the master may overstep its range.
    if ($signed(sp_offset_q) > `RCVR_OFFSET_MAX) begin
      off_clip = `RCVR_OFFSET_MAX;
    end else if ($signed(sp_offset_q) < `RCVR_OFFSET_MIN) begin
      off_clip = `RCVR_OFFSET_MIN;
    end else begin
      off_clip = sp_offset_q;
    end
    if (opmode_d == `RCVR_OM_COMFORT || opmode_d == `RCVR_OM_STANDBY) begin
      eff_sp_d = setpoint_q + {{8{off_clip[7]}}, off_clip};
    end else begin
      eff_sp_d = setpoint_q;
    end
    manual = (ctrl_d == `RCVR_CM_MANUAL);
  end

  always @(posedge clk) begin
    if (reset) begin
      control_mode       <= `RCVR_CM_AUTO;
      operating_mode     <= `RCVR_OM_COMFORT;
      effective_setpoint <= 16'h0000;
      effective_actual   <= 16'h0000;
      changeover_cooling <= 1'b0;
      dew_point_wet      <= 1'b0;
      heat_valve_pct     <= 7'h00;
      cool_valve_pct     <= 7'h00;
      pulse_out_a        <= 7'h00;
      pulse_out_b        <= 7'h00;
      analog_out_a       <= 7'h00;
      analog_out_b       <= 7'h00;
    end else begin
      control_mode       <= ctrl_d;
      operating_mode     <= opmode_d;
      effective_setpoint <= eff_sp_d;
      effective_actual   <= bus_temp_select_cfg ? bus_temp_q :
                            temperature_value;
      changeover_cooling <= changeover_q;
      dew_point_wet      <= dew_point_q;
      heat_valve_pct     <= rcvr_limit(manual ? man_heat_q :
                                       app_heat_valve, heat_limit_q);
      cool_valve_pct     <= rcvr_limit(manual ? man_cool_q :
                                       app_cool_valve, cool_limit_q);
      pulse_out_a        <= rcvr_invert(pulse_out_a_free ? pulse_a_drive_q :
                            app_pulse_a,
                            inversion_q[`RCVR_INV_PULSE_A]);
      pulse_out_b        <= rcvr_invert(pulse_out_b_free ? pulse_b_drive_q :
                            app_pulse_b,
                            inversion_q[`RCVR_INV_PULSE_B]);
      analog_out_a       <= rcvr_invert(analog_out_a_free ? ana_a_drive_q :
                            app_analog_a,
                            inversion_q[`RCVR_INV_ANA_A]);
      analog_out_b       <= rcvr_invert(analog_out_b_free ? ana_b_drive_q :
                            app_analog_b,
                            inversion_q[`RCVR_INV_ANA_B]);
    end
  end

  // Read path: one cycle latency, unmapped numbers read as zero.
  reg [31:0] rd_d;

  always @* begin
    case (reg_addr)
      `RCVR_REG_MAN_ADJUST:   rd_d = {{24{manual_adjust_value[7]}},
                                      manual_adjust_value};
      `RCVR_REG_PRESENCE:     rd_d = {31'h00000000, ~presence_q};
      `RCVR_REG_BUS_TEMP:     rd_d = {16'h0000, bus_temp_q};
      `RCVR_REG_CTRL_REQ:     rd_d = {28'h0000000, ctrl_req_q};
      `RCVR_REG_SP_OFFSET:    rd_d = {{24{sp_offset_q[7]}}, sp_offset_q};
      `RCVR_REG_OPMODE_REQ:   rd_d = {29'h00000000, opmode_req_q};
      `RCVR_REG_CHANGEOVER:   rd_d = {31'h00000000, changeover_q};
      `RCVR_REG_DEW_POINT:    rd_d = {31'h00000000, dew_point_q};
      `RCVR_REG_SETPOINT:     rd_d = {16'h0000, setpoint_q};
      `RCVR_REG_ANA_A_DRIVE:  rd_d = rcvr_pct_word(ana_a_drive_q);
      `RCVR_REG_ANA_B_DRIVE:  rd_d = rcvr_pct_word(ana_b_drive_q);
      `RCVR_REG_PULSE_A_DRIVE: rd_d = rcvr_pct_word(pulse_a_drive_q);
      `RCVR_REG_PULSE_B_DRIVE: rd_d = rcvr_pct_word(pulse_b_drive_q);
      `RCVR_REG_EFF_ACTUAL:   rd_d = {16'h0000, effective_actual};
      `RCVR_REG_CTRL_CUR:     rd_d = {28'h0000000, control_mode};
      `RCVR_REG_WINDOW:       rd_d = {31'h00000000,
                                      window_contact_input};
      `RCVR_REG_EFF_SETPOINT: rd_d = {16'h0000, effective_setpoint};
      `RCVR_REG_MAN_HEAT:     rd_d = rcvr_pct_word(man_heat_q);
      `RCVR_REG_MAN_COOL:     rd_d = rcvr_pct_word(man_cool_q);
      `RCVR_REG_OPMODE_CUR:   rd_d = {29'h00000000, operating_mode};
      `RCVR_REG_AUX_CONTACT:  rd_d = {31'h00000000,
                                      aux_contact_input};
      `RCVR_REG_TEMPERATURE:  rd_d = {16'h0000, temperature_value};
      `RCVR_REG_VOLTAGE:      rd_d = {16'h0000, aux_voltage_input};
      `RCVR_REG_COOL_LIMIT:   rd_d = rcvr_pct_word(cool_limit_q);
      `RCVR_REG_HEAT_LIMIT:   rd_d = rcvr_pct_word(heat_limit_q);
      `RCVR_REG_INVERSION:    rd_d = {28'h0000000, inversion_q};
      default:                rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata  <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_d;
      end
    end
  end

endmodule // rcvr_value_regs
`default_nettype wire

// ### rcvr_chk.sv
// Assertion checker for the room controller value registers.
`timescale 1ns/1ns
`default_nettype none
module rcvr_chk (
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Window polarity setting and field inputs
  input wire logic        window_polarity_cfg,
  input wire logic        window_contact_input,
  input wire logic [15:0] temperature_value,
  input wire logic [15:0] aux_voltage_input,
  // Derived outputs
  input wire logic [3:0]  control_mode,
  input wire logic        changeover_cooling,
  input wire logic        dew_point_wet,
  input wire logic [6:0]  heat_valve_pct,
  input wire logic [6:0]  cool_valve_pct,
  input wire logic [6:0]  pulse_out_a
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Polarity only matters for the frost decision, not for the raw read.
  wire open_w = window_contact_input ^ window_polarity_cfg;
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_window_frost: assert property (open_w |=> control_mode == 4'h5)
    else $error("open window without frost mode");
  a_mode_follow: assert property (reg_wr && reg_addr == 8'h1F && !open_w
    ##1 !open_w |=> control_mode == $past(reg_wdata[3:0], 2))
    else $error("requested control mode not taken");
  a_read_temp: assert property (reg_rd && reg_addr == 8'h47
    |=> reg_rdata == {16'h0000, $past(temperature_value)})
    else $error("temperature read wrong");
  a_read_volt: assert property (reg_rd && reg_addr == 8'h48
    |=> reg_rdata == {16'h0000, $past(aux_voltage_input)})
    else $error("voltage read wrong");
  a_read_window: assert property (reg_rd && reg_addr == 8'h35
    |=> reg_rdata == {31'h0, $past(window_contact_input)})
    else $error("window read wrong");
  a_change_over: assert property (reg_wr && reg_addr == 8'h26
    |-> ##2 changeover_cooling == $past(reg_wdata[0], 2))
    else $error("change-over output wrong");
  a_dew_point: assert property (reg_wr && reg_addr == 8'h27
    |-> ##2 dew_point_wet == $past(reg_wdata[0], 2))
    else $error("dew-point output wrong");
  a_pct_bound: assert property (heat_valve_pct <= 7'h64
    && cool_valve_pct <= 7'h64 && pulse_out_a <= 7'h64)
    else $error("percentage above full scale");
endmodule // rcvr_chk

bind rcvr_value_regs rcvr_chk u_chk (
  .clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .reg_rvalid, .window_polarity_cfg, .window_contact_input,
  .temperature_value, .aux_voltage_input, .control_mode,
  .changeover_cooling, .dew_point_wet, .heat_valve_pct, .cool_valve_pct,
  .pulse_out_a
);
`default_nettype wire

// ### rcvr_master.sv
// Bus master model that reads and writes the value registers.
`timescale 1ns/1ns
`default_nettype none
module rcvr_master (
  // Clock and register port
  input  wire logic        clk,
  output var  logic [7:0]  reg_addr,
  output var  logic        reg_wr,
  output var  logic [31:0] reg_wdata,
  output var  logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 42'h0;
  // Callers send legal codes and in-range values only.
  // Idle address and data show the inverse so stale values never match.
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    // Read data is settled and stands from here until the next read.
    d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge clk);
    #1;
  endtask
endmodule // rcvr_master
`default_nettype wire

// ### rcvr_value_regs_tb.sv
// Self-checking bench for the room controller value registers.
`timescale 1ns/1ns
`default_nettype none
module rcvr_value_regs_tb;
  logic        clk, reset, reg_wr, reg_rd, reg_rvalid, presence_detected;
  logic        window_polarity_cfg, bus_temp_select_cfg, window_contact_input;
  logic        aux_contact_input, changeover_cooling, dew_point_wet;
  logic        pulse_out_a_free, pulse_out_b_free;
  logic        analog_out_a_free, analog_out_b_free;
  logic [2:0]  operating_mode;
  logic [3:0]  control_mode;
  logic [4:0]  rundown_steps_cfg;
  logic [7:0]  reg_addr, manual_adjust_value;
  logic [15:0] base_setpoint_cfg, temperature_value, aux_voltage_input;
  logic [15:0] effective_setpoint, effective_actual;
  logic [31:0] reg_wdata, reg_rdata, rd_data;
  logic [6:0]  app_pulse_a, app_pulse_b, app_analog_a, app_analog_b;
  logic [6:0]  app_heat_valve, app_cool_valve, heat_valve_pct, cool_valve_pct;
  logic [6:0]  pulse_out_a, pulse_out_b, analog_out_a, analog_out_b;
  int          errors, total_checks;

  // Ten cycles per run-down step keeps the run short.
  rcvr_value_regs #(.RUNDOWN_STEP_CYCLES(40'd10)) dut (
    .clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .base_setpoint_cfg, .rundown_steps_cfg,
    .window_polarity_cfg, .bus_temp_select_cfg, .window_contact_input,
    .aux_contact_input, .temperature_value, .aux_voltage_input,
    .presence_detected, .manual_adjust_value, .pulse_out_a_free,
    .pulse_out_b_free, .analog_out_a_free, .analog_out_b_free,
    .app_pulse_a, .app_pulse_b, .app_analog_a, .app_analog_b,
    .app_heat_valve, .app_cool_valve, .control_mode, .operating_mode,
    .effective_setpoint, .effective_actual, .changeover_cooling,
    .dew_point_wet, .heat_valve_pct, .cool_valve_pct, .pulse_out_a,
    .pulse_out_b, .analog_out_a, .analog_out_b);
  rcvr_master m (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp);
    m.rd(a, rd_data);
    chk(rd_data, exp);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task summarize;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_reset;
    rc(8'h8E, 32'h64);
    rc(8'h29, 32'hDC);
    m.wr(8'h29, 32'hC8);
    m.wr(8'h8E, 32'h32);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    rc(8'h29, 32'hDC);
    rc(8'h8E, 32'h64);
    rc(8'h8F, 32'h64);
  endtask
  task t_modes;
    logic [3:0] code [6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'hA};
    foreach (code[i]) begin
      m.wr(8'h1F, {28'h0, code[i]});
      rc(8'h1F, {28'h0, code[i]});
      rc(8'h33, {28'h0, code[i]});
    end
  endtask
  task t_manual;
    m.wr(8'h38, 32'h32);
    m.wr(8'h39, 32'h46);
    m.wr(8'h8F, 32'h1E);
    cyc(2);
    chk(32'(heat_valve_pct), 32'h1E);
    chk(32'(cool_valve_pct), 32'h46);
    m.wr(8'h1F, 32'h0);
    cyc(2);
    chk(32'(heat_valve_pct), 32'h14);
  endtask
  task t_outputs;
    logic [7:0] adr [4] = '{8'h2F, 8'h30, 8'h2D, 8'h2E};
    foreach (adr[i]) m.wr(adr[i], 32'h0A * (i + 1));
    chk(32'({pulse_out_a, pulse_out_b, analog_out_a, analog_out_b}),
      32'({7'h0A, 7'h14, 7'h1E, 7'h28}));
    m.wr(8'h90, 32'h5);
    cyc(2);
    chk(32'({pulse_out_a, pulse_out_b, analog_out_a, analog_out_b}),
      32'({7'h5A, 7'h14, 7'h46, 7'h28}));
    m.wr(8'h90, 32'hA);
    analog_out_a_free = 1'b0;
    cyc(2);
    chk(32'({pulse_out_a, pulse_out_b, analog_out_a, analog_out_b}),
      32'({7'h0A, 7'h50, 7'h07, 7'h3C}));
  endtask
  task t_inputs;
    {temperature_value, aux_voltage_input} = 32'h0190_03E8;
    aux_contact_input = 1'b1;
    rc(8'h47, 32'h190);
    rc(8'h48, 32'h3E8);
    rc(8'h46, 32'h1);
    m.wr(8'h47, 32'h55);
    rc(8'h47, 32'h190);
    rc(8'h00, 32'h0);
    rc(8'h32, 32'h190);
    rc(8'h16, 32'h1);
    manual_adjust_value = 8'hF6;
    rc(8'h15, 32'hFFFFFFF6);
    bus_temp_select_cfg = 1'b1;
    m.wr(8'h1E, 32'h123);
    rc(8'h32, 32'h123);
    rc(8'h1E, 32'h123);
    m.wr(8'h26, 32'h1);
    m.wr(8'h27, 32'h1);
    rc(8'h27, 32'h1);
    chk(32'({changeover_cooling, dew_point_wet}), 32'h3);
  endtask
  task t_window;
    window_contact_input = 1'b1;
    rc(8'h35, 32'h1);
    {window_polarity_cfg, window_contact_input} = 2'h2;
    rc(8'h35, 32'h0);
    rc(8'h33, 32'h5);
  endtask
  task t_opmode;
    m.wr(8'h29, 32'hC8);
    m.wr(8'h22, 32'hFFFFFFE2);
    rc(8'h22, 32'hFFFFFFE2);
    m.wr(8'h24, 32'h0);
    rc(8'h3B, 32'h0);
    rc(8'h36, 32'hAA);
    m.wr(8'h24, 32'h2);
    rc(8'h3B, 32'h2);
    presence_detected = 1'b1;
    cyc(3);
    rc(8'h3B, 32'h0);
    m.wr(8'h24, 32'h5);
    rc(8'h3B, 32'h1);
    rc(8'h36, 32'hC8);
    m.wr(8'h24, 32'h1);
    cyc(3);
    rc(8'h3B, 32'h0);
    presence_detected = 1'b0;
    cyc(5);
    rc(8'h3B, 32'h0);
    cyc(20);
    rc(8'h3B, 32'h1);
  endtask

  initial begin
    #50000;
    errors++;
    summarize;
  end
  initial begin
    errors = 0;
    total_checks = 0;
    reset = 1'b1;
    base_setpoint_cfg = 16'h00DC;
    rundown_steps_cfg = 5'h01;
    {window_polarity_cfg, bus_temp_select_cfg, window_contact_input} = 3'h0;
    {aux_contact_input, presence_detected, manual_adjust_value} = 10'h000;
    {temperature_value, aux_voltage_input} = 32'h00FA_0064;
    {pulse_out_a_free, pulse_out_b_free} = 2'h3;
    {analog_out_a_free, analog_out_b_free} = 2'h3;
    {app_pulse_a, app_pulse_b} = {7'h05, 7'h06};
    {app_analog_a, app_analog_b} = {7'h07, 7'h08};
    {app_heat_valve, app_cool_valve} = {7'h14, 7'h15};
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset;
    t_modes;
    t_manual;
    t_outputs;
    t_inputs;
    t_opmode;
    t_window;
    summarize;
  end
endmodule // rcvr_value_regs_tb
`default_nettype wire
